//--- design/cotb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module cotb_bank
	import cotb_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Factory values, one 16-bit word per slot, slot 0 in the low bits
	input wire logic [COTB_NUM_TRIM*TRIM_WIDTH-1:0] fuse_data,
	// Corrections toward the converter cores
	output cotb_trim_t core_a_trim,
	output cotb_trim_t core_b_trim
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [TRIM_WIDTH-1:0] trim_q [COTB_NUM_TRIM]; // Trim words
	cotb_sel_t sel; // Routing control
	logic load_pending; // High for the first cycle after reset
	logic loaded; // Fuse values have landed
	logic wr_pend; // Write data phase in progress
	logic [9:0] wr_idx; // Index latched in the address phase
	logic addr_ok; // Upper address bits clear and word aligned
	logic [9:0] ad_idx; // Index presented now
	logic take; // Address phase accepted this edge

	assign addr_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
	assign ad_idx = haddr[11:2];
	assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	////////////////////////////////////////////////////////////////////////
	// Fuse load sequencing
	// The fuse bus is sampled one edge after release, never under reset itself,
	// so the reset stays a pure constant load
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			load_pending <= 1'b1;
			loaded <= 1'b0;
		end else begin
			load_pending <= 1'b0;
			if (load_pending) begin
				loaded <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_pend <= 1'b0;
			wr_idx <= 10'h000;
		end else if (hready) begin
			// Only word writes into the low window are remembered
			wr_pend <= take && hwrite && addr_ok && (hsize == 3'h2);
			wr_idx <= ad_idx;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trim words
	genvar gi;
	generate
		for (gi = 0; gi < COTB_NUM_TRIM; gi++) begin : g_trim
			cotb_trim_reg #(
				.WIDTH(TRIM_WIDTH)
			) u_trim (
				.clock(clock),
				.sys_rst(sys_rst),
				.load(load_pending),
				.fuse_value(fuse_data[gi*TRIM_WIDTH +: TRIM_WIDTH]),
				.write_en(wr_pend && (wr_idx == TRIM_IDX[gi])),
				.write_data(hwdata[TRIM_WIDTH-1:0]),
				.value(trim_q[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Control word write
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sel <= cotb_sel_t'(CTRL_RESET);
		end else if (wr_pend && (wr_idx == TRIM_CONTROL_IDX)) begin
			sel <= cotb_sel_t'(hwdata[CTRL_B_PH90_BIT:CTRL_FG_ENABLE_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, produced at the address phase edge
	// A read that directly follows a write to the same word takes the write
	// data, so software never sees a stale value in the back-to-back case
	logic [31:0] next_hrdata; // Read value before registering
	always_comb begin
		next_hrdata = 32'h00000000;
		for (int i = 0; i < COTB_NUM_TRIM; i++) begin
			if (ad_idx == TRIM_IDX[i]) begin
				// All sixteen bits store, reserved ones included
				next_hrdata = {16'h0000, trim_q[i]};
				if (wr_pend && wr_idx == ad_idx) begin
					next_hrdata = {16'h0000, hwdata[TRIM_WIDTH-1:0]};
				end
			end
		end
		if (ad_idx == TRIM_CONTROL_IDX) begin
			next_hrdata[CTRL_B_PH90_BIT:CTRL_FG_ENABLE_BIT] = sel;
			if (wr_pend && wr_idx == ad_idx) begin
				next_hrdata[CTRL_B_PH90_BIT:CTRL_FG_ENABLE_BIT] = hwdata[CTRL_B_PH90_BIT:CTRL_FG_ENABLE_BIT];
			end
			// Status shows the routing actually applied
			next_hrdata[STAT_A_VALID_BIT] = core_a_trim.valid;
			next_hrdata[STAT_B_VALID_BIT] = core_b_trim.valid;
			next_hrdata[STAT_LOADED_BIT] = loaded;
		end
		// Unmapped or non-word reads return zero
		if (!addr_ok || hsize != 3'h2) begin
			next_hrdata = 32'h00000000;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core A routing: one of four words, chosen by pair and phase
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			core_a_trim <= '0;
		end else if (!sel.fg_enable) begin
			core_a_trim <= '0;
		end else begin
			core_a_trim.valid <= 1'b1;
			case ({sel.a_ph90, sel.a_inb})
				2'h0: core_a_trim.value <= trim_q[SLOT_A_INA_PH0][OFFSET_MSB:0];
				2'h1: core_a_trim.value <= trim_q[SLOT_A_INB_PH0][OFFSET_MSB:0];
				2'h2: core_a_trim.value <= trim_q[SLOT_A_INA_PH90][OFFSET_MSB:0];
				2'h3: core_a_trim.value <= trim_q[SLOT_A_INB_PH90][OFFSET_MSB:0];
				default: core_a_trim.value <= 12'h000;
			endcase
		end
	end

	// Core B routing: only 0 degree words live in this bank, so a 90 degree
	// selection leaves core B without a correction from here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			core_b_trim <= '0;
		end else if (!sel.fg_enable || sel.b_ph90) begin
			core_b_trim <= '0;
		end else if (sel.b_inb) begin
			core_b_trim.valid <= 1'b1;
			core_b_trim.value <= trim_q[SLOT_B_INB_PH0][OFFSET_MSB:0];
		end else begin
			core_b_trim.valid <= 1'b1;
			core_b_trim.value <= trim_q[SLOT_B_INA_PH0][OFFSET_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	core_a_b0_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && sel.a_inb && !sel.a_ph90) |=>
		(core_a_trim.valid && core_a_trim.value == $past(trim_q[SLOT_A_INB_PH0][OFFSET_MSB:0])))
		else $error("core A pair B 0 deg trim wrong");

	core_a_a90_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && !sel.a_inb && sel.a_ph90) |=>
		(core_a_trim.value == $past(trim_q[SLOT_A_INA_PH90][OFFSET_MSB:0])))
		else $error("core A pair A 90 deg trim wrong");

	core_a_b90_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && sel.a_inb && sel.a_ph90) |=>
		(core_a_trim.valid && core_a_trim.value == $past(trim_q[SLOT_A_INB_PH90][OFFSET_MSB:0])))
		else $error("core A pair B 90 deg trim wrong");

	core_b_a0_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && !sel.b_inb && !sel.b_ph90) |=>
		(core_b_trim.valid && core_b_trim.value == $past(trim_q[SLOT_B_INA_PH0][OFFSET_MSB:0])))
		else $error("core B pair A trim wrong");

	core_b_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_pend && wr_idx == CORE_B_INB_PHASE0_OFFSET_IDX && !load_pending) |=>
		(trim_q[SLOT_B_INB_PH0] == $past(hwdata[TRIM_WIDTH-1:0])))
		else $error("core B pair B word not written");

	// The release edge still shows load_pending from reset, so start only once reset is sampled low
	fuse_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		(load_pending && !sys_rst) |=> (trim_q[SLOT_A_INA_PH0] == $past(fuse_data[TRIM_WIDTH-1:0]) && loaded)
		##1 !load_pending [*3])
		else $error("fuse value not loaded after reset");

	core_a_a0_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && !sel.a_inb && !sel.a_ph90) |=>
		(core_a_trim.valid && core_a_trim.value == $past(trim_q[SLOT_A_INA_PH0][OFFSET_MSB:0])))
		else $error("core A pair A 0 deg trim wrong");

	fg_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sel.fg_enable) |=> (!core_a_trim.valid && !core_b_trim.valid))
		else $error("trim routed without calibration enabled");

	////////////////////////////////////////////////////////////////////////
	// Further checks on routing, storage and the bus answer
	// These watch the words themselves, so a broken load order shows up; the read check leaves out reads that take the write bypass

	// Core A pair A at 90 degrees must also be marked valid
	a_ph90_valid_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && !sel.a_inb && sel.a_ph90) |=>
		core_a_trim.valid)
		else $error("core A pair A 90 deg not valid");

	// Core B pair B at 0 degrees takes the low twelve bits only
	core_b_b0_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && sel.b_inb && !sel.b_ph90) |=>
		(core_b_trim.valid && core_b_trim.value == $past(trim_q[SLOT_B_INB_PH0][OFFSET_MSB:0])))
		else $error("core B pair B trim wrong");

	// No 90 degree word for core B lives here, so nothing is routed
	core_b_ph90_a: assert property (@(posedge clock) disable iff (sys_rst)
		(sel.fg_enable && sel.b_ph90) |=>
		(!core_b_trim.valid && core_b_trim.value == 12'h000))
		else $error("core B routed at 90 deg");

	// Without calibration both corrections read as zero, not a stale word
	fg_value_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sel.fg_enable) |=>
		(core_a_trim.value == 12'h000 && core_b_trim.value == 12'h000))
		else $error("trim value left without calibration enabled");

	// A control write lands in the selection one edge later
	ctrl_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_pend && wr_idx == TRIM_CONTROL_IDX) |=>
		(sel == $past(hwdata[CTRL_B_PH90_BIT:CTRL_FG_ENABLE_BIT])))
		else $error("routing selection not written");

	// A trim word changes only by fuse load or by its own write
	trim_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!load_pending && !(wr_pend && wr_idx == CORE_A_INB_PHASE0_OFFSET_IDX)) |=>
		$stable(trim_q[SLOT_A_INB_PH0]))
		else $error("trim word changed without a write");

	// Fuse load reaches the last slot as well as the first
	slot_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		(load_pending && !sys_rst) |=>
		(trim_q[SLOT_B_INB_PH0] == $past(fuse_data[SLOT_B_INB_PH0*TRIM_WIDTH +: TRIM_WIDTH])))
		else $error("fuse value not loaded into last slot");

	// Once loaded the status stays up until the next reset
	loaded_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!load_pending) |->
		loaded)
		else $error("loaded status dropped");

	// A word read returns the stored value with the top half clear
	trim_read_a: assert property (@(posedge clock) disable iff (sys_rst)
		(take && !hwrite && addr_ok && hsize == 3'h2 && ad_idx == CORE_A_INA_PHASE0_OFFSET_IDX
		&& !(wr_pend && wr_idx == ad_idx)) |=>
		(hrdata == {16'h0000, $past(trim_q[SLOT_A_INA_PH0])}))
		else $error("trim word read back wrong");

	// Reads of any other size return zero
	short_read_a: assert property (@(posedge clock) disable iff (sys_rst)
		(take && !hwrite && hsize != 3'h2) |=>
		(hrdata == 32'h00000000))
		else $error("non-word read returned data");

	// The bank never stalls and never errors
	bus_okay_a: assert property (@(posedge clock) disable iff (sys_rst)
		hsel |->
		(hreadyout && !hresp))
		else $error("bus answer not ready and okay");

endmodule
`default_nettype wire

//--- design/cotb_pkg.sv
package cotb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices as printed; the byte address is four times the index
	localparam int COTB_NUM_TRIM = 6;
	localparam logic [9:0] CORE_A_INA_PHASE0_OFFSET_IDX = 10'h344;
	localparam logic [9:0] CORE_A_INB_PHASE0_OFFSET_IDX = 10'h346;
	localparam logic [9:0] CORE_A_INA_PHASE90_OFFSET_IDX = 10'h348;
	localparam logic [9:0] CORE_A_INB_PHASE90_OFFSET_IDX = 10'h34a;
	localparam logic [9:0] CORE_B_INA_PHASE0_OFFSET_IDX = 10'h34c;
	localparam logic [9:0] CORE_B_INB_PHASE0_OFFSET_IDX = 10'h34e;
	// Routing control and status word
	localparam logic [9:0] TRIM_CONTROL_IDX = 10'h350;

	// Slot numbers of the trim array, in index order
	localparam int SLOT_A_INA_PH0 = 0;
	localparam int SLOT_A_INB_PH0 = 1;
	localparam int SLOT_A_INA_PH90 = 2;
	localparam int SLOT_A_INB_PH90 = 3;
	localparam int SLOT_B_INA_PH0 = 4;
	localparam int SLOT_B_INB_PH0 = 5;

	// Index of each slot, used by the decoder loop
	localparam logic [9:0] TRIM_IDX [COTB_NUM_TRIM] = '{
		CORE_A_INA_PHASE0_OFFSET_IDX, CORE_A_INB_PHASE0_OFFSET_IDX,
		CORE_A_INA_PHASE90_OFFSET_IDX, CORE_A_INB_PHASE90_OFFSET_IDX,
		CORE_B_INA_PHASE0_OFFSET_IDX, CORE_B_INB_PHASE0_OFFSET_IDX};

	////////////////////////////////////////////////////////////////////////
	// Field layout
	localparam int TRIM_WIDTH = 16;
	localparam int OFFSET_MSB = 11;
	localparam int CTRL_FG_ENABLE_BIT = 0;
	localparam int CTRL_A_INB_BIT = 1;
	localparam int CTRL_A_PH90_BIT = 2;
	localparam int CTRL_B_INB_BIT = 3;
	localparam int CTRL_B_PH90_BIT = 4;
	localparam int STAT_A_VALID_BIT = 8;
	localparam int STAT_B_VALID_BIT = 9;
	localparam int STAT_LOADED_BIT = 10;

	// Reset values
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// AHB transfer types
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	// Routing selection held in the control word
	typedef struct packed {
		logic b_ph90;
		logic b_inb;
		logic a_ph90;
		logic a_inb;
		logic fg_enable;
	} cotb_sel_t;

	// Correction handed to one core
	typedef struct packed {
		logic valid;
		logic [11:0] value;
	} cotb_trim_t;

endpackage

//--- design/cotb_trim_reg.sv
`timescale 1ns/1ps
`default_nettype none
// One trim word: fuse load on power-up, software write afterwards
module cotb_trim_reg
	import cotb_pkg::*;
#(
	parameter int WIDTH = TRIM_WIDTH
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] fuse_value,
	input wire logic write_en,
	input wire logic [WIDTH-1:0] write_data,
	output logic [WIDTH-1:0] value
);

	// Fuse load outranks a write; both cannot meet since load is the first cycle only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			value <= WIDTH'(TRIM_RESET);
		end else if (load) begin
			value <= fuse_value;
		end else if (write_en) begin
			value <= write_data;
		end
	end

endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the offset trim bank
module tb
	import cotb_pkg::*;
;
	logic clock = 1'b0; // Bench clock, 100 MHz
	logic sys_rst = 1'b1; // Held high from time zero
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready; // Single slave: bus ready is the slave's own ready
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [COTB_NUM_TRIM*TRIM_WIDTH-1:0] fuse_data = '0;
	cotb_trim_t core_a_trim;
	cotb_trim_t core_b_trim;
	int mismatches = 0; // Count of failed comparisons
	int checks_done = 0; // Count of all comparisons
	logic [15:0] mtrim [COTB_NUM_TRIM]; // Reference copy of the trim words
	logic [4:0] mctrl = 5'h00; // Reference copy of the routing selection
	logic [31:0] rd;

	assign hready = hreadyout;

	cotb_bank uut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .fuse_data(fuse_data), .core_a_trim(core_a_trim),
		.core_b_trim(core_b_trim));

	// Free-running clock
	always #5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Single AHB-Lite transfer; it waits on ready as long as needed, only the watchdog ends a stuck one
	task bus(input logic [9:0] idx, input logic w, input logic [2:0] sz, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= sz;
		do begin
			@(posedge clock);
		end while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clock);
		end while (hready !== 1'b1);
		r = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	// Reset with fresh factory values; the model takes the same values
	task do_reset;
		int i;
		sys_rst <= 1'b1;
		fuse_data <= {$urandom(), $urandom(), $urandom()};
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (i = 0; i < COTB_NUM_TRIM; i++) begin
			mtrim[i] = fuse_data[i*16 +: 16];
		end
		mctrl = 5'h00;
	endtask

	// Every trim word read back against the model
	task check_words;
		int i;
		for (i = 0; i < COTB_NUM_TRIM; i++) begin
			bus(TRIM_IDX[i], 1'b0, 3'h2, 32'h0, rd);
			check(rd, {16'h0, mtrim[i]});
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Expected core corrections: core A picks pair and phase, core B has no 90 degree word
	function automatic logic [31:0] exp_a();
		if (!mctrl[0]) return 32'h0;
		return {19'h0, 1'b1, mtrim[{mctrl[2], mctrl[1]}][11:0]};
	endfunction

	function automatic logic [31:0] exp_b();
		if (!mctrl[0] || mctrl[4]) return 32'h0;
		return {19'h0, 1'b1, mtrim[4 + mctrl[3]][11:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int i;
		int c;
		logic [31:0] d;
		logic [31:0] ea;
		logic [31:0] eb;
		void'($urandom(32'h03ae093f));
		do_reset();
		@(posedge clock);
		check_words();
		// Full sixteen bits store, reserved top nibble included
		for (i = 0; i < COTB_NUM_TRIM; i++) begin
			d = $urandom();
			bus(TRIM_IDX[i], 1'b1, 3'h2, d, rd);
			mtrim[i] = d[15:0];
		end
		check_words();
		// Non-word size is ignored and unmapped places read zero
		bus(TRIM_IDX[5], 1'b1, 3'h1, $urandom(), rd);
		bus(TRIM_IDX[5], 1'b0, 3'h2, 32'h0, rd);
		check(rd, {16'h0, mtrim[5]});
		bus(10'h345, 1'b1, 3'h2, 32'hffffffff, rd);
		bus(10'h345, 1'b0, 3'h2, 32'h0, rd);
		check(rd, 32'h0);
		bus(TRIM_IDX[0], 1'b0, 3'h1, 32'h0, rd);
		check(rd, 32'h0);
		// Every routing combination, with noise in the unused data bits
		for (c = 0; c < 32; c++) begin
			d = $urandom();
			d[4:0] = c[4:0];
			bus(TRIM_CONTROL_IDX, 1'b1, 3'h2, d, rd);
			mctrl = c[4:0];
			repeat (2) @(posedge clock);
			#1;
			ea = exp_a();
			eb = exp_b();
			check({19'h0, core_a_trim}, ea);
			check({19'h0, core_b_trim}, eb);
			bus(TRIM_CONTROL_IDX, 1'b0, 3'h2, 32'h0, rd);
			check(rd, {21'h0, 1'b1, eb[12], ea[12], 3'h0, mctrl});
		end
		// A second reset in mid-run reloads new factory values
		do_reset();
		@(posedge clock);
		#1;
		check({19'h0, core_a_trim}, 32'h0);
		check_words();
		conclude();
	end

	// Watchdog: the whole run needs a few hundred cycles
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
